// ---- rtl/rtchw_map.vh ----
// Register map, field positions and reset values of the hour and weekday stage.
// Assumes inclusion by its bare name from the design file.
`ifndef RTCHW_MAP_VH
`define RTCHW_MAP_VH

// ********************************************************
// Register offsets
// ********************************************************
`define RTCHW_ADDR_HOUR      2'h0
`define RTCHW_ADDR_WEEKDAY   2'h1
`define RTCHW_ADDR_CTRL      2'h2

// ********************************************************
// Field positions
// ********************************************************
`define RTCHW_BIT_BUSY       7
`define RTCHW_BIT_FMT24      6
`define RTCHW_BIT_PM         5
`define RTCHW_HR_TENS_HI     5
`define RTCHW_HR_TENS_LO     4
`define RTCHW_HR_UNITS_HI    3
`define RTCHW_WK_HI          2

// ********************************************************
// Values and reset values
// ********************************************************
`define RTCHW_UNITS_MAX      4'h9
`define RTCHW_HOUR_MAX_12    6'h11
`define RTCHW_HOUR_MAX_24    6'h23
`define RTCHW_WK_SATURDAY    3'h6
`define RTCHW_WK_SUNDAY      3'h0
`define RTCHW_HOUR_RESET     6'h00
`define RTCHW_WK_RESET       3'h0
`define RTCHW_RD_UNMAPPED    8'h00

`endif

// ---- rtl/rtchw_counter.v ----
// Hour and day-of-week counting stages of a calendar clock.
// Assumes a one-cycle hourly carry from the minute stage and a busy level
// from the seconds/minute logic, all synchronous to core_clk.
// How it works
// R01 - Hour advances in BCD on minute carry
// R02 - Range 00-11 or 00-23 by format
// R03 - Bit 7 of both registers shows busy
// R04 - Software trusts values read while busy 0
// R05 - Hour bit 6 always reads zero
// R06 - Hour bits 5:4 tens digit, 0-2
// R07 - Hour bits 3:0 units 0-9, writable
// R08 - Weekday advances on daily hour carry
// R09 - Weekday bits 2:0, range 0-6, read/write
// R10 - Binary code, Sunday zero; 111 never written
// R11 - Weekday bits 6:3 always read zero
// R12 - Format 0 twelve-hour, 1 twenty-four-hour
// R13 - Afternoon flag 0 morning, 1 afternoon
// R14 - Wrap to 00; PM toggles; day carry
// R15 - Weekday wraps Saturday to Sunday
`timescale 1ns/1ps
`include "rtchw_map.vh"
`default_nettype none

module rtchw_counter #(
  parameter ADDR_W = 2
) (
  input  wire              core_clk,
  input  wire              rst,
  input  wire              minute_carry,
  input  wire              update_busy,
  input  wire [ADDR_W-1:0] reg_addr,
  input  wire [7:0]        reg_wdata,
  input  wire              reg_wr,
  input  wire              reg_rd,
  output reg  [7:0]        reg_rdata,
  output wire              day_carry,
  output wire              week_carry,
  output wire              fmt24_out,
  output wire              afternoon_flag
);

  // ********************************************************
  // BCD helper
  // ********************************************************
  function [5:0] rtchw_bcd_inc;
    input [5:0] v;
    begin
      if (v[`RTCHW_HR_UNITS_HI:0] == `RTCHW_UNITS_MAX) begin
        rtchw_bcd_inc = {v[`RTCHW_HR_TENS_HI:`RTCHW_HR_TENS_LO] + 2'h1, 4'h0};
      end else begin
        rtchw_bcd_inc = {v[`RTCHW_HR_TENS_HI:`RTCHW_HR_TENS_LO],
                         v[`RTCHW_HR_UNITS_HI:0] + 4'h1};
      end
    end
  endfunction

  // ********************************************************
  // State
  // ********************************************************
  reg  [5:0] hour_reg;
  reg  [5:0] hour_next;
  reg  [2:0] weekday_reg;
  reg  [2:0] weekday_next;
  reg        fmt24_reg;
  reg        pm_reg;
  reg        pm_next;
  reg        day_carry_c;
  wire [5:0] hour_max;
  wire       wr_hour;
  wire       wr_wk;
  wire       wr_ctrl;

  assign hour_max = fmt24_reg ? `RTCHW_HOUR_MAX_24 : `RTCHW_HOUR_MAX_12; // R02 R12
  assign wr_hour  = reg_wr && (reg_addr == `RTCHW_ADDR_HOUR);
  assign wr_wk    = reg_wr && (reg_addr == `RTCHW_ADDR_WEEKDAY);
  assign wr_ctrl  = reg_wr && (reg_addr == `RTCHW_ADDR_CTRL);

  // ********************************************************
  // Hour stage
  // ********************************************************
  always @* begin
    hour_next   = hour_reg;
    pm_next     = pm_reg;
    day_carry_c = 1'b0;
    if (minute_carry) begin
      if (hour_reg >= hour_max) begin
        hour_next = `RTCHW_HOUR_RESET; // R14
        if (fmt24_reg) begin
          day_carry_c = 1'b1; // R14
        end else begin
          pm_next     = ~pm_reg; // R13 R14
          day_carry_c = pm_reg; // R14
        end
      end else begin
        hour_next = rtchw_bcd_inc(hour_reg); // R01 R06 R07
      end
    end
    // Software write wins over a count in the same cycle
    if (wr_hour) begin
      hour_next = reg_wdata[`RTCHW_HR_TENS_HI:0]; // R07
    end
    if (wr_ctrl) begin
      pm_next = reg_wdata[`RTCHW_BIT_PM]; // R13
    end
  end

  // ********************************************************
  // Weekday stage
  // ********************************************************
  always @* begin
    weekday_next = weekday_reg;
    if (day_carry_c) begin
      if (weekday_reg >= `RTCHW_WK_SATURDAY) begin
        weekday_next = `RTCHW_WK_SUNDAY; // R15
      end else begin
        weekday_next = weekday_reg + 3'h1; // R08 R10
      end
    end
    if (wr_wk) begin
      weekday_next = reg_wdata[`RTCHW_WK_HI:0]; // R09
    end
  end

  always @(posedge core_clk) begin
    if (rst) begin
      hour_reg    <= `RTCHW_HOUR_RESET;
      weekday_reg <= `RTCHW_WK_RESET;
      fmt24_reg   <= 1'b0;
      pm_reg      <= 1'b0;
    end else begin
      hour_reg    <= hour_next;
      weekday_reg <= weekday_next;
      pm_reg      <= pm_next;
      if (wr_ctrl) begin
        fmt24_reg <= reg_wdata[`RTCHW_BIT_FMT24]; // R12
      end
    end
  end

  assign day_carry      = day_carry_c;
  assign week_carry     = day_carry_c && (weekday_reg >= `RTCHW_WK_SATURDAY);
  assign fmt24_out      = fmt24_reg;
  assign afternoon_flag = pm_reg; // R13

  // ********************************************************
  // Read port
  // ********************************************************
  // Busy is sampled at the read strobe so software sees the state it raced
  always @(posedge core_clk) begin
    if (rst) begin
      reg_rdata <= `RTCHW_RD_UNMAPPED;
    end else if (reg_rd) begin
      case (reg_addr)
        `RTCHW_ADDR_HOUR: begin
          reg_rdata <= {update_busy, 1'b0, hour_reg}; // R03 R05 R04
        end
        `RTCHW_ADDR_WEEKDAY: begin
          reg_rdata <= {update_busy, 4'h0, weekday_reg}; // R03 R11
        end
        `RTCHW_ADDR_CTRL: begin
          reg_rdata <= {1'b0, fmt24_reg, pm_reg, 5'h00};
        end
        default: begin
          reg_rdata <= `RTCHW_RD_UNMAPPED;
        end
      endcase
    end else begin
      reg_rdata <= `RTCHW_RD_UNMAPPED;
    end
  end

endmodule // rtchw_counter

`default_nettype wire

// ---- verification/rtchw_chk_assertions.sv ----
// Checker on the hour and weekday stage ports.
// Assumes bind from tb and software that never writes weekday 7.
`timescale 1ns/1ps
`default_nettype none
module rtchw_chk (
  input wire logic       core_clk,
  input wire logic       rst,
  input wire logic       minute_carry,
  input wire logic       update_busy,
  input wire logic [1:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic       reg_wr,
  input wire logic       reg_rd,
  input wire logic [7:0] reg_rdata,
  input wire logic       day_carry,
  input wire logic       week_carry,
  input wire logic       fmt24_out,
  input wire logic       afternoon_flag
);
  // ******
  // Read tracking: data stands one cycle after the strobe
  // ******
  default clocking @(posedge core_clk); endclocking
  default disable iff (rst);
  logic       rd_q;
  logic [1:0] a_q;
  always_ff @(posedge core_clk) begin
    rd_q <= reg_rd;
    a_q  <= reg_addr;
  end
  AST_BUSY: assert property (rd_q && !a_q[1] |->
    reg_rdata[7] == $past(update_busy)) else $error("busy bit wrong");
  AST_HR_RSV: assert property (rd_q && a_q == 2'h0 |->
    !reg_rdata[6]) else $error("hour bit 6 set");
  AST_HR_BCD: assert property (rd_q && a_q == 2'h0 |->
    reg_rdata[5:4] <= 2'h2 && reg_rdata[3:0] <= 4'h9) else $error("hour not BCD");
  AST_WK_RSV: assert property (rd_q && a_q == 2'h1 |->
    reg_rdata[6:3] == 4'h0 && reg_rdata[2:0] != 3'h7) else $error("weekday bad");
  AST_DAY_SRC: assert property (day_carry |-> minute_carry)
    else $error("day carry without hour carry");
  AST_WEEK: assert property (week_carry |-> day_carry)
    else $error("week carry without day carry");
  AST_PM_DAY: assert property (day_carry && !fmt24_out |->
    afternoon_flag ##1 !afternoon_flag) else $error("day carry not on pm fall");
  AST_PM_SRC: assert property ($changed(afternoon_flag) |->
    $past(reg_wr) && $past(reg_addr) == 2'h2 || $past(minute_carry) && !$past(fmt24_out))
    else $error("afternoon flag moved alone");
  AST_FMT: assert property ($changed(fmt24_out) |->
    $past(reg_wr) && $past(reg_addr) == 2'h2) else $error("format moved alone");
  cover property (week_carry);
  cover property (day_carry && fmt24_out);
  cover property (day_carry && !fmt24_out);
endmodule // rtchw_chk
`default_nettype wire

// ---- verification/tb.sv ----
// Bench: corner and seeded random traffic on the hour and weekday stage.
// Assumes design and checker compiled first.
`timescale 1ns/1ps
`default_nettype none
module tb;
  logic       core_clk, rst, minute_carry, update_busy, reg_wr, reg_rd;
  logic [1:0] reg_addr;
  logic [7:0] reg_wdata, v;
  wire  [7:0] reg_rdata;
  wire        day_carry, week_carry, fmt24_out, afternoon_flag;
  integer     seed = 40855, n_mismatch = 0, checks_done = 0, cyc = 0, h = 0, w = 0, i;
  logic       pm = 0, f24 = 0;
  rtchw_counter rtchw_counter_i (
    .core_clk(core_clk), .rst(rst), .minute_carry(minute_carry), .update_busy(update_busy),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .day_carry(day_carry), .week_carry(week_carry),
    .fmt24_out(fmt24_out), .afternoon_flag(afternoon_flag));
  initial begin
    core_clk = 0;
    forever #5 core_clk = ~core_clk;
  end
  // Cut a hang short
  always @(posedge core_clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      n_mismatch = n_mismatch + 1;
      final_report;
    end
  end
  function automatic [7:0] bcd(input integer x);
    bcd = {2'h0, 2'(x / 10), 4'(x % 10)};
  endfunction
  task automatic chk(input string n, input logic [7:0] s, e);
    checks_done++;
    if (s !== e) begin
      n_mismatch++;
      $display("MISMATCH %s exp %h seen %h", n, e, s);
    end
  endtask
  task automatic wr(input logic [1:0] a, input logic [7:0] d);
    @(posedge core_clk); reg_wr <= 1; reg_addr <= a; reg_wdata <= d;
    @(posedge core_clk); reg_wr <= 0;
  endtask
  task automatic rd(input logic [1:0] a);
    @(posedge core_clk); reg_rd <= 1; reg_addr <= a; update_busy <= 1'($random(seed));
    @(posedge core_clk); reg_rd <= 0;
    #1 v = reg_rdata;
  endtask
  task automatic check_all;
    rd(2'h0); chk("hour", v, bcd(h) | {update_busy, 7'h00});
    rd(2'h1); chk("weekday", v, {update_busy, 4'h0, 3'(w)});
    rd(2'h2); chk("control", v, {1'b0, f24, pm, 5'h00});
    chk("flags", {6'h00, fmt24_out, afternoon_flag}, {6'h00, f24, pm});
  endtask
  task automatic tick;
    logic dc;
    dc = (h >= (f24 ? 23 : 11)) && (f24 || pm);
    @(posedge core_clk); minute_carry <= 1;
    #1 chk("day_carry", {7'h00, day_carry}, {7'h00, dc});
    chk("week_carry", {7'h00, week_carry}, {7'h00, dc && (w == 6)});
    @(posedge core_clk); minute_carry <= 0;
    if (h >= (f24 ? 23 : 11)) begin
      h = 0;
      if (!f24) pm = !pm;
      if (f24 || !pm) w = (w == 6) ? 0 : w + 1;
    end else h = h + 1;
  endtask
  initial begin
    rst = 1; minute_carry = 0; update_busy = 0;
    reg_wr = 0; reg_rd = 0; reg_addr = 0; reg_wdata = 0;
    repeat (16) @(posedge core_clk);
    rst <= 0;
    check_all;
    rd(2'h3); chk("unmapped", v, 8'h00);
    wr(2'h2, 8'h20); wr(2'h0, 8'h11); wr(2'h1, 8'h06);
    pm = 1; h = 11; w = 6;
    tick; check_all;
    $display("test corner done");
    for (i = 0; i < 400; i++) begin
      case ({$random(seed)} % 6)
        0: begin
          f24 = 1'($random(seed)); pm = 1'($random(seed)); h = h % (f24 ? 24 : 12);
          wr(2'h2, {1'b0, f24, pm, 5'h00}); wr(2'h0, bcd(h));
        end
        1: begin w = {$random(seed)} % 7; wr(2'h1, 8'(w)); end
        2: begin h = {$random(seed)} % (f24 ? 24 : 12); wr(2'h0, bcd(h)); end
        default: tick;
      endcase
      check_all;
    end
    wr(2'h3, 8'hFF); check_all;
    $display("test random done");
    final_report;
  end
  task final_report;
    $display("checks %0d mismatches %0d", checks_done, n_mismatch);
    if (n_mismatch == 0 && checks_done > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
endmodule // tb
bind rtchw_counter rtchw_chk chk_i (
  .core_clk(core_clk), .rst(rst), .minute_carry(minute_carry), .update_busy(update_busy),
  .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
  .reg_rdata(reg_rdata), .day_carry(day_carry), .week_carry(week_carry),
  .fmt24_out(fmt24_out), .afternoon_flag(afternoon_flag));
`default_nettype wire
